// *** adc_host_pkg.sv ***
// constants shared by the converter host read port
// assumes a single 10 mhz system clock drives every file
`default_nettype none
package adc_host_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_RATE_HZ = 100_000;
  // cycles per conversion period at the 100 khz sample rate
  localparam int unsigned SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  // conversion clock half period in system cycles
  localparam int unsigned CONV_CLK_HALF_CYC = 1;
  // sample_hold_control stays high this long after a period starts
  localparam int unsigned HOLD_HIGH_CYC = 20;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] WINDOW_LO = 16'h3000;
  localparam logic [15:0] WINDOW_HI = 16'h37ff;
  localparam int unsigned WAIT_STATES = 1;
  localparam int unsigned AVG_COUNT = 4;
  localparam int unsigned AVG_SHIFT = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_READ = 2'b11,
    ST_DONE = 2'b10
  } read_state_t;
endpackage
`default_nettype wire

// *** conv_timing.sv ***
// conversion clock and sample_hold_control generator
// assumes one system clock; outputs are registered levels
`default_nettype none
module conv_timing #(
  parameter int unsigned PERIOD = adc_host_pkg::SAMPLE_PERIOD_CYC,
  parameter int unsigned HOLD = adc_host_pkg::HOLD_HIGH_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic busy_in,
  output logic conv_clk_out,
  output logic sample_hold_out
);
  logic [15:0] period_count;
  logic [15:0] half_count;

  ////////////////////////////////////////////////////////////////////
  // sample period counter, divided from the system clock
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !enable_in)
      period_count <= 16'h0000;
    else if (period_count == 16'(PERIOD - 1))
      period_count <= 16'h0000;
    else
      period_count <= period_count + 16'h0001;
  end

  // low after the hold window captures the input
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !enable_in)
      sample_hold_out <= 1'b1;
    else
      sample_hold_out <= (period_count < 16'(HOLD - 1)) ||
        (period_count == 16'(PERIOD - 1));
  end

  ////////////////////////////////////////////////////////////////////
  // conversion clock, gated by busy so it stops between conversions
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !enable_in)
    begin
      half_count <= 16'h0000;
      conv_clk_out <= 1'b0;
    end
    else if (half_count ==
      16'(adc_host_pkg::CONV_CLK_HALF_CYC - 1))
    begin
      half_count <= 16'h0000;
      conv_clk_out <= busy_in ? ~conv_clk_out : 1'b0;
    end
    else
      half_count <= half_count + 16'h0001;
  end
endmodule
`default_nettype wire

// *** result_avg.sv ***
// averages a run of consecutive conversion results
// assumes results arrive as one-cycle strobes with a data word
`default_nettype none
module result_avg #(
  parameter int unsigned W = adc_host_pkg::DATA_W,
  parameter int unsigned SHIFT = adc_host_pkg::AVG_SHIFT
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sample_valid_in,
  input wire logic [W-1:0] sample_in,
  output logic avg_valid_out,
  output logic [W-1:0] avg_out
);
  logic [W+SHIFT-1:0] acc;
  logic [SHIFT-1:0] count;
  logic [W+SHIFT-1:0] sum;

  always_comb
  begin
    sum = acc + {{SHIFT{1'b0}}, sample_in};
  end

  // average of 2**shift results narrows the code spread
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      acc <= '0;
      count <= '0;
      avg_valid_out <= 1'b0;
      avg_out <= '0;
    end
    else
    begin
      avg_valid_out <= 1'b0;
      if (sample_valid_in)
      begin
        count <= count + 1'b1;
        if (count == {SHIFT{1'b1}})
        begin
          acc <= '0;
          avg_out <= sum[W+SHIFT-1:SHIFT];
          avg_valid_out <= 1'b1;
        end
        else
          acc <= sum;
      end
    end
  end
endmodule
`default_nettype wire

// *** adc_result_host_read_port.sv ***
// host controller reading a 16-bit sampling converter through buffers
// assumes busy and data pins are synchronous to clock_in
`default_nettype none
module adc_result_host_read_port #(
  parameter int unsigned W = adc_host_pkg::DATA_W,
  parameter logic [15:0] RESULT_ADDR = adc_host_pkg::WINDOW_LO,
  parameter int unsigned WAITS = adc_host_pkg::WAIT_STATES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic io_mapped_in,
  input wire logic busy_in,
  input wire logic [W-1:0] adc_data_in,
  output logic conv_clk_out,
  output logic sample_hold_out,
  output logic buf_enable_n_out,
  output logic [15:0] addr_out,
  output logic mem_sel_out,
  output logic io_sel_out,
  output logic result_valid_out,
  output logic [W-1:0] result_out,
  output logic avg_valid_out,
  output logic [W-1:0] avg_out,
  output logic overrun_out
);
  adc_host_pkg::read_state_t state;
  adc_host_pkg::read_state_t next_state;
  logic busy_prev;
  logic busy_fall;
  logic busy_rise;
  logic pending;
  logic [3:0] wait_count;
  logic addr_hit;
  logic strobe;
  logic [W-1:0] word;
  logic clk_int;
  logic sh_int;
  logic avg_v;
  logic [W-1:0] avg_w;

  ////////////////////////////////////////////////////////////////////
  // clock and sample generation
  conv_timing u_timing (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .enable_in(enable_in),
    .busy_in(busy_in),
    .conv_clk_out(clk_int),
    .sample_hold_out(sh_int)
  );

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      conv_clk_out <= 1'b0;
      sample_hold_out <= 1'b1;
    end
    else
    begin
      conv_clk_out <= clk_int;
      sample_hold_out <= sh_int;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data-ready edge detection
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      busy_prev <= 1'b0;
    else
      busy_prev <= busy_in;
  end

  assign busy_fall = busy_prev && !busy_in;
  assign busy_rise = !busy_prev && busy_in;

  // edge latched internally so it is acknowledged before busy rises
  // only an edge seen mid-read is latched; idle edges start at once,
  // so one busy fall never yields a second read
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pending <= 1'b0;
    else if (busy_fall && state != adc_host_pkg::ST_IDLE)
      pending <= 1'b1;
    else if (state == adc_host_pkg::ST_IDLE || !enable_in)
      pending <= 1'b0;
  end

  // a new busy rise while a read is still in flight is reported
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      overrun_out <= 1'b0;
    else if (busy_rise && state != adc_host_pkg::ST_IDLE)
      overrun_out <= 1'b1;
    else if (!enable_in)
      overrun_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // read sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      adc_host_pkg::ST_IDLE:
        if (busy_fall || pending)
          next_state = adc_host_pkg::ST_WAIT;
      adc_host_pkg::ST_WAIT:
        if (wait_count == 4'(WAITS))
          next_state = adc_host_pkg::ST_READ;
      adc_host_pkg::ST_READ:
        next_state = adc_host_pkg::ST_DONE;
      adc_host_pkg::ST_DONE:
        next_state = adc_host_pkg::ST_IDLE;
      default:
        next_state = adc_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in || !enable_in)
      state <= adc_host_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in || state != adc_host_pkg::ST_WAIT)
      wait_count <= 4'h0;
    else
      wait_count <= wait_count + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // address decode; bit 0 forced low keeps the word access whole
  assign addr_hit = (RESULT_ADDR >= adc_host_pkg::WINDOW_LO) &&
    (RESULT_ADDR <= adc_host_pkg::WINDOW_HI);

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      addr_out <= 16'h0000;
      mem_sel_out <= 1'b0;
      io_sel_out <= 1'b0;
      buf_enable_n_out <= 1'b1;
    end
    else if (enable_in && (next_state == adc_host_pkg::ST_WAIT ||
      next_state == adc_host_pkg::ST_READ))
    begin
      addr_out <= {RESULT_ADDR[15:1], 1'b0};
      mem_sel_out <= !io_mapped_in;
      io_sel_out <= io_mapped_in;
      // buffers drive only for memory reads in the window
      buf_enable_n_out <= !(addr_hit && !io_mapped_in);
    end
    else
    begin
      mem_sel_out <= 1'b0;
      io_sel_out <= 1'b0;
      buf_enable_n_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // whole-word capture in one read cycle
  assign strobe = state == adc_host_pkg::ST_READ;
  assign word = adc_data_in;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      result_out <= '0;
      result_valid_out <= 1'b0;
    end
    else
    begin
      result_valid_out <= strobe;
      if (strobe)
        result_out <= word;
    end
  end

  // decimation by block averaging for in-band noise
  result_avg u_avg (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .sample_valid_in(strobe),
    .sample_in(word),
    .avg_valid_out(avg_v),
    .avg_out(avg_w)
  );

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      avg_valid_out <= 1'b0;
      avg_out <= '0;
    end
    else
    begin
      avg_valid_out <= avg_v;
      avg_out <= avg_w;
    end
  end
endmodule
`default_nettype wire

// *** adc_port_props.sv ***
// checker for the converter host read port
// bound onto adc_result_host_read_port, one clock domain
`default_nettype none
module adc_port_chk #(
  parameter int unsigned W = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic busy_in,
  input wire logic conv_clk_out,
  input wire logic sample_hold_out,
  input wire logic buf_enable_n_out,
  input wire logic [15:0] addr_out,
  input wire logic mem_sel_out,
  input wire logic io_sel_out,
  input wire logic result_valid_out,
  input wire logic [W-1:0] result_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire sel = mem_sel_out | io_sel_out;
  ////////////////////////////////////////////////////////////////////////
  AST_SEL_START: assert property (
    $fell(busy_in) && enable_in && !sel && !result_valid_out
    && !$past(rst_in) |=> sel)
    else $error("no access after busy fell");
  AST_WAIT_STATE: assert property (
    $rose(sel) |-> sel [*3] ##1 (!sel && result_valid_out))
    else $error("access length wrong");
  AST_VALID_PULSE: assert property (
    result_valid_out |=> !result_valid_out)
    else $error("valid longer than one cycle");
  AST_HOLD: assert property (
    !result_valid_out |-> $stable(result_out))
    else $error("result changed without valid");
  AST_ADDR: assert property (
    sel |-> !addr_out[0] && addr_out >= 16'h3000 && addr_out <= 16'h37ff)
    else $error("address outside window");
  AST_BUF_ONLY: assert property (
    !buf_enable_n_out |-> mem_sel_out && !io_sel_out)
    else $error("buffers enabled outside memory read");
  AST_BUF_MEM: assert property (
    mem_sel_out |-> !buf_enable_n_out)
    else $error("memory read without buffers");
  AST_CLK_GATE: assert property (
    !busy_in ##1 !busy_in |=> !conv_clk_out)
    else $error("conversion clock runs while idle");
  AST_PERIOD: assert property (
    $fell(sample_hold_out) |-> ##100 ($fell(sample_hold_out) || !enable_in))
    else $error("sample period wrong");
  cover property (io_sel_out);
  cover property (mem_sel_out);
  cover property ($fell(busy_in) && sel);
endmodule
bind adc_result_host_read_port adc_port_chk #(.W(W)) adc_port_chk_inst (
  .clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
  .busy_in(busy_in), .conv_clk_out(conv_clk_out),
  .sample_hold_out(sample_hold_out), .buf_enable_n_out(buf_enable_n_out),
  .addr_out(addr_out), .mem_sel_out(mem_sel_out), .io_sel_out(io_sel_out),
  .result_valid_out(result_valid_out), .result_out(result_out));
`default_nettype wire

// *** adc_conv_model.sv ***
// converter model: busy flag, held result word, gated buffers
// assumes the host's system clock and synchronous reset
`default_nettype none
module adc_conv_model #(
  parameter int unsigned CONV_CYC = 40
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sample_hold_in,
  input wire logic buf_enable_n_in,
  input wire logic io_sel_in,
  input wire logic [15:0] word_in,
  input wire logic glitch_in,
  output logic busy_out,
  output logic [15:0] data_out
);
  logic conv;
  logic sh_q;
  logic [7:0] left;
  logic [15:0] held;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in)
  begin
    sh_q <= sample_hold_in;
    if (rst_in)
    begin
      conv <= 1'b0;
      held <= 16'h0000;
    end
    else if (sh_q && !sample_hold_in)
    begin
      conv <= 1'b1;
      left <= 8'(CONV_CYC);
    end
    else if (conv && left == 8'h00)
    begin
      conv <= 1'b0;
      held <= word_in;
    end
    else if (conv)
      left <= left - 8'h01;
  end
  // glitch only when a scenario wants a misbehaving converter
  assign busy_out = conv | glitch_in;
  // closed buffers show the inverse of the held word, except during an io_sel_in access
  assign data_out = (!buf_enable_n_in || io_sel_in) ? held : ~held;
endmodule
`default_nettype wire

// *** test_adc_result_host_read_port.sv ***
// self-checking bench for the converter host read port
// inputs change 5 ns after each rising edge of a 10 mhz clock
`default_nettype none
module test_adc_result_host_read_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, rst_in = 1, enable_in = 0, io_mapped_in = 0, glitch = 0;
  logic busy, cclk, sh, bufn, msel, isel, rv, av, ovr;
  logic [15:0] data, addr, res, avg, got_avg, word = 0;
  int n_fail = 0, tests_run = 0, n_avg = 0;
  adc_result_host_read_port adc_result_host_read_port_inst (
    .clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
    .io_mapped_in(io_mapped_in), .busy_in(busy), .adc_data_in(data),
    .conv_clk_out(cclk), .sample_hold_out(sh), .buf_enable_n_out(bufn),
    .addr_out(addr), .mem_sel_out(msel), .io_sel_out(isel),
    .result_valid_out(rv), .result_out(res), .avg_valid_out(av),
    .avg_out(avg), .overrun_out(ovr));
  adc_conv_model adc_conv_model_inst (
    .clock_in(clock_in), .rst_in(rst_in), .sample_hold_in(sh),
    .buf_enable_n_in(bufn), .io_sel_in(isel), .word_in(word),
    .glitch_in(glitch), .busy_out(busy), .data_out(data));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic ok);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t output mismatch", $time);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #5;
  endtask
  // bounded: a converter that never finishes ends the run
  task automatic wait_fall;
    logic prev;
    prev = busy;
    for (int i = 0; i < 300; i++)
    begin
      tick(1);
      if (prev && !busy)
        return;
      prev = busy;
    end
    n_fail++;
    $display("ERROR %0t busy never fell", $time);
    end_of_test();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_read(input logic io, input logic [15:0] w);
    io_mapped_in = io;
    word = w;
    wait_fall();
    tick(2);
    chk(isel === io && msel === !io);
    chk(bufn === io && addr === 16'h3000);
    tick(2);
    chk(rv === 1'b1 && res === w);
    tick(1);
    chk(rv === 1'b0 && res === w);
    chk(cclk === 1'b0);
  endtask
  task automatic t_avg;
    logic [15:0] ws [4] = '{16'h8000, 16'h8004, 16'h7ffc, 16'h0011};
    logic [17:0] sum;
    sum = 0;
    for (int k = 0; k < 4; k++)
    begin
      t_read(1'b0, ws[k]);
      sum = sum + 18'(ws[k]);
    end
    tick(2);
    chk(n_avg == 1 && got_avg === sum[17:2]);
  endtask
  task automatic t_overrun;
    io_mapped_in = 0;
    wait_fall();
    tick(1);
    glitch = 1;
    tick(1);
    glitch = 0;
    tick(3);
    chk(ovr === 1'b1);
    enable_in = 0;
    tick(3);
    chk(ovr === 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(negedge clock_in)
    if (av === 1'b1)
    begin
      n_avg++;
      got_avg = avg;
    end
  initial
  begin
    clock_in = 0;
    forever #50 clock_in = ~clock_in;
  end
  initial
  begin
    tick(16);
    rst_in = 0;
    enable_in = 1;
    tick(1);
    chk(sh === 1'b1 && bufn === 1'b1 && rv === 1'b0);
    t_avg();
    t_read(1'b1, 16'ha5c3);
    t_overrun();
    end_of_test();
  end
endmodule
`default_nettype wire
